/* verilog/acc_pkg.sv */
`default_nettype none
package acc_pkg;
    // =====================================================
    // Register map (byte addresses, word index = addr[15:4])
    // =====================================================
    localparam int NUM_CMP = 3;
    localparam logic [15:0] CMP1_CTL_OFS = 16'hA000;
    localparam logic [15:0] CMP2_CTL_OFS = 16'hA010;
    localparam logic [15:0] CMP3_CTL_OFS = 16'hA020;
    localparam logic [15:0] SHARED_STAT_OFS = 16'hA060;
    localparam logic [15:0] EVT_STAT_OFS = 16'hA070;
    localparam logic [15:0] EVT_MASK_OFS = 16'hA080;

    // Alias kinds, addr[3:2]
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INV = 2'h3;

    // =====================================================
    // Control register fields
    // =====================================================
    localparam int CTL_ON_BIT = 15;
    localparam int CTL_OE_BIT = 14;
    localparam int CTL_INV_BIT = 13;
    localparam int CTL_RES_BIT = 8;
    localparam int CTL_EDGE_LSB = 6;
    localparam int CTL_PREF_BIT = 4;
    localparam int CTL_NSEL_LSB = 0;
    localparam logic [15:0] CTL_WMASK = 16'hE0D3;
    localparam logic [15:0] CTL_RESET = 16'h00C3;

    // Edge select encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // =====================================================
    // Shared status fields
    // =====================================================
    localparam int STAT_HALT_BIT = 13;
    localparam logic [15:0] STAT_WMASK = 16'h2000;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [2:0] EVT_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* verilog/acc_top.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RQ1] Bit 15 enables a comparator; other fields keep their values.
// [RQ2] Bit 14 drives the comparator result onto its output pin.
// [RQ3] Bit 13 inverts the result before it is presented.
// [RQ4] Inversion also feeds the edge detector, flipping the firing edge.
// [RQ5] Read-only bit 8 shows the comparator's current result.
// [RQ6] Bits 7-6 pick event edge: both, falling, rising or none.
// [RQ7] Bit 4 picks ladder reference or pin A for positive input.
// [RQ8] Bits 1-0 pick absolute reference, pin D, C or B.
// [RQ9] Unimplemented bits read zero and ignore writes.
// [RQ10] Shared halt bit stops all comparators while in Idle.
// [RQ11] Shared status mirrors results three, two, one at bits 2..0.
// [RQ12] Clear, set and invert aliases sit at +0x4, +0x8, +0xC.
// [RQ13] Software avoids access right after clearing an enable bit.
// [RQ14] Control registers reset to 0x00C3.
// [RQ15] Raw results pass two flip-flops before readback and edges; the code adds a third (res_r), so they pass three.
// [RQ16] A stopped comparator raises no event and holds its result.
module acc_top #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_mode,
    input wire logic [2:0] cmp_raw,
    output logic [2:0] cmp_power_on,
    output logic [2:0] positive_input_ref_select,
    output logic [5:0] negative_input_select,
    output logic [2:0] result_output_pin,
    output logic [2:0] result_output_pin_oe,
    output logic irq
);

    // =====================================================
    // Reset release
    // =====================================================
    logic [1:0] rst_pipe_r;
    logic rst_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // =====================================================
    // State
    // =====================================================
    logic [15:0] ctl_r [acc_pkg::NUM_CMP];
    logic [15:0] stat_r;
    logic [2:0] evt_r;
    logic [2:0] mask_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] res_r;
    logic [2:0] prev_r;
    logic [2:0] run;
    logic [2:0] fire;

    // Masked write with byte strobes and alias kind
    function automatic logic [15:0] acc_apply(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] strb, input logic [1:0] kind,
                                              input logic [15:0] wmask);
        logic [15:0] m;
        logic [15:0] v;
        m = wmask & {{8{strb[1]}}, {8{strb[0]}}}; // RQ9
        v = d[15:0] & m;
        case (kind)
            acc_pkg::ALIAS_CLR: acc_apply = old & ~v; // RQ12
            acc_pkg::ALIAS_SET: acc_apply = old | v; // RQ12
            acc_pkg::ALIAS_INV: acc_apply = old ^ v; // RQ12
            default: acc_apply = (old & ~m) | v;
        endcase
    endfunction

    function automatic logic [11:0] ctl_base(input int i);
        if (i == 0) begin
            ctl_base = acc_pkg::CMP1_CTL_OFS[15:4];
        end else if (i == 1) begin
            ctl_base = acc_pkg::CMP2_CTL_OFS[15:4];
        end else begin
            ctl_base = acc_pkg::CMP3_CTL_OFS[15:4];
        end
    endfunction

    // =====================================================
    // AXI4-Lite write channel
    // =====================================================
    logic aw_got_r;
    logic w_got_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    logic [11:0] wr_idx;
    logic [1:0] wr_kind;
    logic wr_hit;

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_idx = aw_addr_r[15:4];
    assign wr_kind = aw_addr_r[3:2];

    always_comb begin
        if (wr_idx == acc_pkg::CMP1_CTL_OFS[15:4]) begin
            wr_hit = 1'b1;
        end else if (wr_idx == acc_pkg::CMP2_CTL_OFS[15:4]) begin
            wr_hit = 1'b1;
        end else if (wr_idx == acc_pkg::CMP3_CTL_OFS[15:4]) begin
            wr_hit = 1'b1;
        end else if (wr_idx == acc_pkg::SHARED_STAT_OFS[15:4]) begin
            wr_hit = 1'b1;
        end else if (wr_idx == acc_pkg::EVT_STAT_OFS[15:4]) begin
            wr_hit = 1'b1;
        end else if (wr_idx == acc_pkg::EVT_MASK_OFS[15:4]) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= acc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // Register writes
    // =====================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
                ctl_r[i] <= acc_pkg::CTL_RESET; // RQ14
            end
        end else if (wr_go) begin
            for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
                if (wr_idx == ctl_base(i)) begin
                    ctl_r[i] <= acc_apply(ctl_r[i], w_data_r, w_strb_r, wr_kind, acc_pkg::CTL_WMASK); // RQ1
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= acc_pkg::STAT_RESET;
        end else if (wr_go && wr_idx == acc_pkg::SHARED_STAT_OFS[15:4]) begin
            stat_r <= acc_apply(stat_r, w_data_r, w_strb_r, wr_kind, acc_pkg::STAT_WMASK);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= acc_pkg::MASK_RESET;
        end else if (wr_go && wr_idx == acc_pkg::EVT_MASK_OFS[15:4]) begin
            mask_r <= 3'(acc_apply({13'h0, mask_r}, w_data_r, w_strb_r, wr_kind, 16'h0007));
        end
    end

    // =====================================================
    // Comparator results and events
    // =====================================================
    always_comb begin
        for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
            run[i] = ctl_r[i][acc_pkg::CTL_ON_BIT] && !(stat_r[acc_pkg::STAT_HALT_BIT] && idle_mode); // RQ1 RQ10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
                // Frozen while off: an unpowered core output is never sampled
                if (run[i]) begin
                    sync1_r[i] <= cmp_raw[i]; // RQ15
                    sync2_r[i] <= sync1_r[i]; // RQ15 RQ16
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_r <= 3'h0;
            prev_r <= 3'h0;
        end else begin
            for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
                if (run[i]) begin
                    res_r[i] <= sync2_r[i] ^ ctl_r[i][acc_pkg::CTL_INV_BIT]; // RQ3 RQ4 RQ16
                end
            end
            prev_r <= res_r;
        end
    end

    always_comb begin
        for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
            case (ctl_r[i][acc_pkg::CTL_EDGE_LSB +: 2]) // RQ6
                acc_pkg::EDGE_RISE: fire[i] = res_r[i] && !prev_r[i];
                acc_pkg::EDGE_FALL: fire[i] = !res_r[i] && prev_r[i];
                acc_pkg::EDGE_BOTH: fire[i] = res_r[i] != prev_r[i];
                default: fire[i] = 1'b0;
            endcase
            fire[i] = fire[i] && run[i]; // RQ16
        end
    end

    // =====================================================
    // AXI4-Lite read channel
    // =====================================================
    logic [11:0] rd_idx;
    logic [1:0] rd_kind;
    logic [31:0] rd_data;
    logic rd_err;
    logic rd_clr;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[15:4];
    assign rd_kind = s_axi_araddr[3:2];
    assign rd_clr = s_axi_arvalid && s_axi_arready && rd_idx == acc_pkg::EVT_STAT_OFS[15:4]
                    && rd_kind == acc_pkg::ALIAS_WRITE;

    function automatic logic [31:0] ctl_view(input logic [15:0] c, input logic r);
        logic [15:0] v;
        v = c & acc_pkg::CTL_WMASK; // RQ9
        v[acc_pkg::CTL_RES_BIT] = r; // RQ5
        ctl_view = {16'h0, v};
    endfunction

    always_comb begin
        rd_data = 32'h0;
        rd_err = 1'b0;
        if (rd_kind != acc_pkg::ALIAS_WRITE) begin
            rd_err = 1'b0;
        end else if (rd_idx == acc_pkg::CMP1_CTL_OFS[15:4]) begin
            rd_data = ctl_view(ctl_r[0], res_r[0]);
        end else if (rd_idx == acc_pkg::CMP2_CTL_OFS[15:4]) begin
            rd_data = ctl_view(ctl_r[1], res_r[1]);
        end else if (rd_idx == acc_pkg::CMP3_CTL_OFS[15:4]) begin
            rd_data = ctl_view(ctl_r[2], res_r[2]);
        end else if (rd_idx == acc_pkg::SHARED_STAT_OFS[15:4]) begin
            rd_data = {16'h0, stat_r & acc_pkg::STAT_WMASK} | {29'h0, res_r}; // RQ11
        end else if (rd_idx == acc_pkg::EVT_STAT_OFS[15:4]) begin
            rd_data = {29'h0, evt_r};
        end else if (rd_idx == acc_pkg::EVT_MASK_OFS[15:4]) begin
            rd_data = {29'h0, mask_r};
        end else begin
            rd_err = 1'b1;
        end
        if (rd_kind != acc_pkg::ALIAS_WRITE && !(rd_idx == acc_pkg::CMP1_CTL_OFS[15:4]
            || rd_idx == acc_pkg::CMP2_CTL_OFS[15:4] || rd_idx == acc_pkg::CMP3_CTL_OFS[15:4]
            || rd_idx == acc_pkg::SHARED_STAT_OFS[15:4] || rd_idx == acc_pkg::EVT_STAT_OFS[15:4]
            || rd_idx == acc_pkg::EVT_MASK_OFS[15:4])) begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= acc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? acc_pkg::RESP_SLVERR : acc_pkg::RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =====================================================
    // Event status and interrupt
    // =====================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= acc_pkg::EVT_RESET;
        end else begin
            // New event wins over the read clear
            evt_r <= (rd_clr ? 3'h0 : evt_r) | fire;
        end
    end

    assign irq = |(evt_r & mask_r);

    // =====================================================
    // Analog side controls
    // =====================================================
    always_comb begin
        for (int i = 0; i < acc_pkg::NUM_CMP; i++) begin
            cmp_power_on[i] = run[i]; // RQ1 RQ10
            positive_input_ref_select[i] = ctl_r[i][acc_pkg::CTL_PREF_BIT]; // RQ7
            negative_input_select[2*i +: 2] = ctl_r[i][acc_pkg::CTL_NSEL_LSB +: 2]; // RQ8
            result_output_pin[i] = res_r[i]; // RQ3
            result_output_pin_oe[i] = ctl_r[i][acc_pkg::CTL_OE_BIT]; // RQ2
        end
    end

endmodule // acc_top
`default_nettype wire

/* bench/acc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] positive_input_ref_select,
    input wire logic [5:0] negative_input_select,
    input wire logic [2:0] result_output_pin_oe
);
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    pin_drive_a: assert property ($changed(result_output_pin_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("pin drive changed without a write");
    input_mux_a: assert property ($changed({positive_input_ref_select, negative_input_select})
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("input select changed without a write");
endmodule // acc_monitor
bind acc_top acc_monitor u_mon (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .positive_input_ref_select, .negative_input_select, .result_output_pin_oe);
`default_nettype wire

/* bench/acc_cmp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model (
    input wire logic clk,
    input wire logic [2:0] power_on,
    input wire logic [2:0] pref,
    input wire logic [5:0] nsel,
    input wire logic [3:0] lvl_a,
    input wire logic [3:0] lvl_b,
    input wire logic [3:0] lvl_c,
    input wire logic [3:0] lvl_d,
    input wire logic [3:0] lvl_lad,
    input wire logic [3:0] lvl_abs,
    output logic [2:0] raw
);
    logic tgl = 1'b0;
    logic [3:0] pos, neg;
    // Unpowered core output is meaningless: churn it
    always @(posedge clk) tgl <= ~tgl;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pos = pref[i] ? lvl_lad : lvl_a;
            case (nsel[2*i+:2])
                2'h0: neg = lvl_b;
                2'h1: neg = lvl_c;
                2'h2: neg = lvl_d;
                default: neg = lvl_abs;
            endcase
            raw[i] = power_on[i] ? (pos > neg) : (tgl ^ i[0]);
        end
    end
endmodule // acc_cmp_model
`default_nettype wire

/* bench/acc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb;
    logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, idle_mode, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, lvl_a, lvl_b, lvl_c, lvl_d, lvl_lad, lvl_abs;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] cmp_raw, cmp_power_on, positive_input_ref_select, result_output_pin, result_output_pin_oe;
    logic [5:0] negative_input_select;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    acc_top dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idle_mode, .cmp_raw,
        .cmp_power_on, .positive_input_ref_select, .negative_input_select, .result_output_pin,
        .result_output_pin_oe, .irq);
    acc_cmp_model peer (.clk, .power_on(cmp_power_on), .pref(positive_input_ref_select),
        .nsel(negative_input_select), .lvl_a, .lvl_b, .lvl_c, .lvl_d, .lvl_lad, .lvl_abs, .raw(cmp_raw));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================
    // Bus cycles and comparison
    // ==========================================
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", er, s_axi_rresp);
        if (er == 2'h0) chk("rdata", e, rv);
        @(posedge clk);
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset;
        for (int i = 0; i < 3; i++) rd(acc_pkg::CMP1_CTL_OFS + 16'(i * 16), 32'h000000C3);
        rd(16'hA060, 32'h0);
        chk("nsel port", 6'h3F, negative_input_select);
        chk("pin drive", 3'h0, result_output_pin_oe);
        rd(16'hA0F0, 32'h0, acc_pkg::RESP_SLVERR);
        wr(16'hA0F0, 32'hFFFFFFFF, acc_pkg::RESP_SLVERR);
        $display("reset test done");
    endtask
    task automatic t_alias;
        wr(16'hA010, 32'hFFFF7FFF);
        rd(16'hA010, 32'h000060D3);
        wr(16'hA014, 32'h000000C0);
        rd(16'hA010, 32'h00006013);
        wr(16'hA01C, 32'h00006003);
        rd(16'hA010, 32'h00000010);
        chk("pref port", 1'b1, positive_input_ref_select[1]);
        wr(16'hA018, 32'h000000C3);
        rd(16'hA010, 32'h000000D3);
        rd(16'hA014, 32'h0);
        s_axi_wstrb <= 4'h1;
        wr(16'hA018, 32'h0000E000);
        rd(16'hA010, 32'h000000D3);
        s_axi_wstrb <= 4'hF;
        $display("alias test done");
    endtask
    task automatic t_mux;
        logic [3:0] e = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            wr(16'hA000, 32'h8000 | i);
            repeat (5) @(posedge clk);
            rd(16'hA000, 32'h8000 | i | (32'(e[i]) << 8));
            rd(16'hA060, 32'(e[i]));
            chk("nsel port", i, negative_input_select[1:0]);
        end
        wr(16'hA000, 32'h00008013);
        repeat (5) @(posedge clk);
        rd(16'hA000, 32'h00008113);
        wr(16'hA004, 32'h00008000);
        chk("power", 1'b0, cmp_power_on[0]);
        rd(16'hA000, 32'h00000113);
        $display("mux test done");
    endtask
    task automatic t_event;
        wr(16'hA080, 32'h1);
        for (int ed = 0; ed < 4; ed++) begin
            wr(16'hA000, 32'hC000 | (ed << 6));
            repeat (5) @(posedge clk);
            lvl_b <= 4'hC;
            repeat (6) @(posedge clk);
            chk("irq", ed[1], irq);
            rd(16'hA070, 32'(ed[1]));
            lvl_b <= 4'h4;
            repeat (6) @(posedge clk);
            rd(16'hA070, 32'(ed[0]));
        end
        wr(16'hA000, 32'h0000E040);
        repeat (5) @(posedge clk);
        chk("pin", 1'b0, result_output_pin[0]);
        chk("pin drive", 1'b1, result_output_pin_oe[0]);
        rd(16'hA070, 32'h0);
        lvl_b <= 4'hC;
        repeat (6) @(posedge clk);
        chk("irq", 1'b1, irq);
        chk("pin", 1'b1, result_output_pin[0]);
        rd(16'hA070, 32'h1);
        chk("irq", 1'b0, irq);
        lvl_b <= 4'h4;
        repeat (6) @(posedge clk);
        rd(16'hA070, 32'h0);
        wr(16'hA080, 32'h0);
        lvl_b <= 4'hC;
        repeat (6) @(posedge clk);
        chk("irq", 1'b0, irq);
        rd(16'hA070, 32'h1);
        lvl_b <= 4'h4;
        repeat (6) @(posedge clk);
        $display("event test done");
    endtask
    task automatic t_idle;
        wr(16'hA000, 32'h0000E0C0);
        wr(16'hA080, 32'h1);
        rd(16'hA070, 32'h0);
        wr(16'hA060, 32'hFFFFFFFF);
        rd(16'hA060, 32'h00002000);
        idle_mode <= 1'b1;
        repeat (2) @(posedge clk);
        chk("power", 3'h0, cmp_power_on);
        repeat (10) @(posedge clk);
        chk("irq", 1'b0, irq);
        rd(16'hA000, 32'h0000E0C0);
        idle_mode <= 1'b0;
        repeat (6) @(posedge clk);
        chk("power", 1'b1, cmp_power_on[0]);
        rd(16'hA070, 32'h0);
        wr(16'hA064, 32'h00002000);
        idle_mode <= 1'b1;
        repeat (2) @(posedge clk);
        chk("power", 1'b1, cmp_power_on[0]);
        idle_mode <= 1'b0;
        $display("idle test done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test;
        end
    end
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, idle_mode} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {lvl_a, lvl_b, lvl_c, lvl_d, lvl_lad, lvl_abs} = {4'h8, 4'h4, 4'hC, 4'h6, 4'hF, 4'h9};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_alias;
        t_mux;
        t_event;
        t_idle;
        finish_test;
    end
endmodule // acc_top_tb
`default_nettype wire
